/* logic/monitor_cfg_pkg.sv */
// What this block does
// - Test bit zero enables tree test mode
// - Lock bit makes these registers read-only, except the aux register
// - Remote-1 offset added to remote-1 temperature
// - Local offset added to local temperature
// - Remote-2 offset added to remote-2 temperature
// - All these registers reset to zero
// - Config bits 0..3 choose two-wire fan sense
// - Config bit 4 enables measurement averaging
// - Config bit 5 bypasses input dividers
// - Config bit 6 selects single-channel conversion
// - Fan-1 minimum bits 7..5 pick channel
// - Test-2 bit 1 selects external conversion clock
// - Config bit 7 shuts down, fans off
//
// Purpose: constants and carriers for the monitor configuration slice
// Assumes: APB slave, 32-bit data, one word per register
// Notes:   printed offsets are register indexes; byte address is 4x
package monitor_cfg_pkg;
  // ==========================================================
  // Register indexes and byte addresses
  localparam logic [7:0]  IDX_TEST_EN   = 8'h6F;
  localparam logic [7:0]  IDX_R1_OFS    = 8'h70;
  localparam logic [7:0]  IDX_LOC_OFS   = 8'h71;
  localparam logic [7:0]  IDX_R2_OFS    = 8'h72;
  localparam logic [7:0]  IDX_CFG_TWO   = 8'h73;
  localparam logic [7:0]  IDX_CTRL_AUX  = 8'hC0;
  localparam logic [7:0]  IDX_STATUS    = 8'hC1;
  localparam logic [9:0]  ADDR_TEST_EN  = {IDX_TEST_EN, 2'b00};
  localparam logic [9:0]  ADDR_R1_OFS   = {IDX_R1_OFS, 2'b00};
  localparam logic [9:0]  ADDR_LOC_OFS  = {IDX_LOC_OFS, 2'b00};
  localparam logic [9:0]  ADDR_R2_OFS   = {IDX_R2_OFS, 2'b00};
  localparam logic [9:0]  ADDR_CFG_TWO  = {IDX_CFG_TWO, 2'b00};
  localparam logic [9:0]  ADDR_CTRL_AUX = {IDX_CTRL_AUX, 2'b00};
  localparam logic [9:0]  ADDR_STATUS   = {IDX_STATUS, 2'b00};
  // ==========================================================
  // Reset values and field positions
  localparam logic [7:0]  RST_REG       = 8'h00;
  localparam int          POS_TEST_EN   = 0;
  localparam int          POS_AVG       = 4;
  localparam int          POS_BYPASS    = 5;
  localparam int          POS_SINGLE    = 6;
  localparam int          POS_POWER_DOWN_MODE      = 7;
  localparam int          POS_LOCK      = 0;
  localparam int          POS_EXT_CLK   = 1;
  localparam int          POS_POLARITY  = 2;
  localparam int          SEL_LSB       = 5;
  // ==========================================================
  // Single-channel selection codes
  localparam logic [2:0]  CH_2V5        = 3'h0;
  localparam logic [2:0]  CH_SUPPLY     = 3'h2;
  localparam logic [2:0]  CH_REMOTE1    = 3'h5;
  localparam logic [2:0]  CH_LOCAL      = 3'h6;
  localparam logic [2:0]  CH_REMOTE2    = 3'h7;

  typedef enum logic [2:0] {
    SEL_2V5, SEL_SUPPLY, SEL_REMOTE1, SEL_LOCAL, SEL_REMOTE2, SEL_NONE
  } chan_sel_t;

  // Raw readings in quarter-degree steps, 10 bits signed
  typedef struct packed {
    logic [9:0] remote1;
    logic [9:0] local_t;
    logic [9:0] remote2;
  } temp_set_t;

  typedef struct packed {
    logic [3:0] two_wire_sense_sel;
    logic       measurement_averaging;
    logic       input_divider_bypass;
    logic       single_channel_convert;
    logic       power_down_mode;
    logic       tree_test_mode_on;
    logic       ext_single_channel_convert_clock;
    chan_sel_t  channel;
  } mode_t;
endpackage

/* logic/monitor_config_offset_regs.sv */
// Purpose: configuration and offset registers of the monitor, APB slave
// Assumes: pclk 20 MHz, presetn async active low, zero-wait APB
// Notes:   aux register holds lock, external clock and polarity bits
module monitor_config_offset_regs (
  input  wire logic                        pclk,       // Bus clock
  input  wire logic                        presetn,    // Async reset
  input  wire logic                        psel,       // Slave select
  input  wire logic                        penable,    // Access phase
  input  wire logic                        pwrite,     // Write strobe
  input  wire logic [11:0]                 paddr,      // Byte address
  input  wire logic [31:0]                 pwdata,     // Write data
  output logic      [31:0]                 prdata,     // Read data
  output logic                             pready,     // Always ready
  output logic                             pslverr,    // Unmapped access
  input  wire logic [7:0]                  fan1_min,   // Fan-1 min reg
  input  wire monitor_cfg_pkg::temp_set_t  temp_raw,   // Raw readings
  input  wire logic [7:0]                  duty_raw,   // Engine duty
  output monitor_cfg_pkg::temp_set_t       temp_adj,   // Offset readings
  output monitor_cfg_pkg::mode_t           mode,       // Decoded modes
  output logic      [7:0]                  duty_shown, // Duty readback
  output logic                             fan_drive   // Fan pins level
);
  import monitor_cfg_pkg::*;

  logic [7:0] test_en;
  logic [7:0] r1_ofs;
  logic [7:0] loc_ofs;
  logic [7:0] r2_ofs;
  logic [7:0] cfg_two;
  logic [7:0] ctrl_aux;
  logic       wr_acc;
  logic       rd_acc;
  logic       hit;
  logic       locked;
  logic [7:0] rd_byte;
  logic [2:0] sel_code;

  // ==========================================================
  // Bus decode
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a[11:10] == 2'b00) &&
             (a[9:0] == ADDR_TEST_EN || a[9:0] == ADDR_R1_OFS ||
              a[9:0] == ADDR_LOC_OFS || a[9:0] == ADDR_R2_OFS ||
              a[9:0] == ADDR_CFG_TWO || a[9:0] == ADDR_CTRL_AUX ||
              a[9:0] == ADDR_STATUS);
  endfunction

  assign hit     = mapped(paddr);
  assign wr_acc  = psel && penable && pwrite && hit;
  assign rd_acc  = psel && !penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign locked  = ctrl_aux[POS_LOCK];

  // ==========================================================
  // Locked registers
  // zero at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_en <= RST_REG;
      r1_ofs  <= RST_REG;
      loc_ofs <= RST_REG;
      r2_ofs  <= RST_REG;
      cfg_two <= RST_REG;
    end else if (wr_acc && !locked) begin
      if (paddr[9:0] == ADDR_TEST_EN) begin
        test_en <= {7'h00, pwdata[POS_TEST_EN]};
      end else if (paddr[9:0] == ADDR_R1_OFS) begin
        r1_ofs <= pwdata[7:0];
      end else if (paddr[9:0] == ADDR_LOC_OFS) begin
        loc_ofs <= pwdata[7:0];
      end else if (paddr[9:0] == ADDR_R2_OFS) begin
        r2_ofs <= pwdata[7:0];
      end else if (paddr[9:0] == ADDR_CFG_TWO) begin
        cfg_two <= pwdata[7:0];
      end
    end
  end

  // Aux control: lock is sticky until reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_aux <= RST_REG;
    end else if (wr_acc && paddr[9:0] == ADDR_CTRL_AUX) begin
      ctrl_aux <= {5'h00, pwdata[POS_POLARITY], pwdata[POS_EXT_CLK],
                   pwdata[POS_LOCK] | locked};
    end
  end

  // ==========================================================
  // Read data, registered in setup phase
  always_comb begin
    if (paddr[9:0] == ADDR_TEST_EN) begin
      rd_byte = test_en;
    end else if (paddr[9:0] == ADDR_R1_OFS) begin
      rd_byte = r1_ofs;
    end else if (paddr[9:0] == ADDR_LOC_OFS) begin
      rd_byte = loc_ofs;
    end else if (paddr[9:0] == ADDR_R2_OFS) begin
      rd_byte = r2_ofs;
    end else if (paddr[9:0] == ADDR_CFG_TWO) begin
      rd_byte = cfg_two;
    end else if (paddr[9:0] == ADDR_CTRL_AUX) begin
      rd_byte = ctrl_aux;
    end else if (paddr[9:0] == ADDR_STATUS) begin
      rd_byte = {mode.channel, 2'b00, locked, cfg_two[POS_POWER_DOWN_MODE],
                 test_en[POS_TEST_EN]};
    end else begin
      rd_byte = 8'h00;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_acc) begin
      // Unmapped reads return zero
      prdata <= hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // ==========================================================
  // Temperature offsets, sign-extended quarter-degree steps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temp_adj <= '0;
    end else begin
      temp_adj.remote1 <= temp_raw.remote1 + {{2{r1_ofs[7]}}, r1_ofs};
      temp_adj.local_t <= temp_raw.local_t + {{2{loc_ofs[7]}}, loc_ofs};
      temp_adj.remote2 <= temp_raw.remote2 + {{2{r2_ofs[7]}}, r2_ofs};
    end
  end

  // ==========================================================
  // Mode outputs
  assign sel_code = fan1_min[SEL_LSB +: 3];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= '{4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, SEL_NONE};
    end else begin
      mode.two_wire_sense_sel    <= cfg_two[3:0];
      mode.measurement_averaging <= cfg_two[POS_AVG];
      mode.input_divider_bypass  <= cfg_two[POS_BYPASS];
      mode.single_channel_convert <= cfg_two[POS_SINGLE];
      mode.power_down_mode       <= cfg_two[POS_POWER_DOWN_MODE];
      mode.tree_test_mode_on     <= test_en[POS_TEST_EN];
      mode.ext_single_channel_convert_clock        <= ctrl_aux[POS_EXT_CLK];
      if (!cfg_two[POS_SINGLE]) begin
        mode.channel <= SEL_NONE;
      end else if (sel_code == CH_2V5) begin
        mode.channel <= SEL_2V5;
      end else if (sel_code == CH_SUPPLY) begin
        mode.channel <= SEL_SUPPLY;
      end else if (sel_code == CH_REMOTE1) begin
        mode.channel <= SEL_REMOTE1;
      end else if (sel_code == CH_LOCAL) begin
        mode.channel <= SEL_LOCAL;
      end else if (sel_code == CH_REMOTE2) begin
        mode.channel <= SEL_REMOTE2;
      end else begin
        mode.channel <= SEL_NONE;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_shown <= 8'h00;
      fan_drive  <= 1'b0;
    end else if (cfg_two[POS_POWER_DOWN_MODE]) begin
      duty_shown <= 8'h00;
      fan_drive  <= ctrl_aux[POS_POLARITY];
    end else begin
      duty_shown <= duty_raw;
      fan_drive  <= ~ctrl_aux[POS_POLARITY];
    end
  end

  // ==========================================================
  // Checks
  lock_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    locked |=> $stable(cfg_two) && $stable(r1_ofs) && $stable(test_en)
      && $stable(loc_ofs) && $stable(r2_ofs))
    else $error("locked register changed");

  lock_sticky_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    locked |=> locked)
    else $error("lock bit cleared");

  reset_zero_a: assert property (
    @(posedge pclk)
    $rose(presetn) |-> test_en == RST_REG && cfg_two == RST_REG
      && r1_ofs == RST_REG && loc_ofs == RST_REG && r2_ofs == RST_REG)
    else $error("register not zero after reset");

  cfg_write_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_acc && !locked && paddr[9:0] == ADDR_CFG_TWO
    |=> cfg_two == $past(pwdata[7:0]))
    else $error("config write lost");

  test_mode_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##1 mode.tree_test_mode_on == $past(test_en[0]))
    else $error("test mode wrong");

  test_upper_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_acc && !locked && paddr[9:0] == ADDR_TEST_EN
    |=> test_en == {7'h00, $past(pwdata[POS_TEST_EN])})
    else $error("test register write wrong");

  remote1_ofs_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##1 temp_adj.remote1 ==
      10'($past(temp_raw.remote1) + {{2{$past(r1_ofs[7])}}, $past(r1_ofs)}))
    else $error("remote1 offset wrong");

  local_ofs_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##1 temp_adj.local_t ==
      10'($past(temp_raw.local_t) + {{2{$past(loc_ofs[7])}}, $past(loc_ofs)}))
    else $error("local offset wrong");

  remote2_ofs_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##1 temp_adj.remote2 ==
      10'($past(temp_raw.remote2) + {{2{$past(r2_ofs[7])}}, $past(r2_ofs)}))
    else $error("remote2 offset wrong");

  sense_sel_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##1 mode.two_wire_sense_sel == $past(cfg_two[3:0]))
    else $error("fan sense select wrong");

  avg_mode_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##1 mode.measurement_averaging == $past(cfg_two[POS_AVG]))
    else $error("averaging mode wrong");

  div_bypass_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##1 mode.input_divider_bypass == $past(cfg_two[POS_BYPASS]))
    else $error("divider bypass wrong");

  single_single_channel_convert_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##1 mode.single_channel_convert == $past(cfg_two[POS_SINGLE]))
    else $error("single channel mode wrong");

  power_down_mode_mode_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##1 mode.power_down_mode == $past(cfg_two[POS_POWER_DOWN_MODE]))
    else $error("shutdown mode wrong");

  ext_clock_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##1 mode.ext_single_channel_convert_clock == $past(ctrl_aux[POS_EXT_CLK]))
    else $error("external clock select wrong");

  cfg_read_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_acc && paddr == {2'b00, ADDR_CFG_TWO}
    |=> prdata == {24'h00_0000, $past(cfg_two)})
    else $error("config readback wrong");

  chan_pick_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    cfg_two[POS_SINGLE] && sel_code == CH_REMOTE1
    |=> mode.channel == SEL_REMOTE1)
    else $error("channel select wrong");

  chan_none_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !cfg_two[POS_SINGLE] |=> mode.channel == SEL_NONE)
    else $error("channel set outside single mode");

  duty_pass_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !cfg_two[POS_POWER_DOWN_MODE] |=> duty_shown == $past(duty_raw)
      && fan_drive == !$past(ctrl_aux[POS_POLARITY]))
    else $error("running fan state wrong");

  power_down_mode_duty_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    cfg_two[POS_POWER_DOWN_MODE] |=> duty_shown == 8'h00
      && fan_drive == $past(ctrl_aux[POS_POLARITY]))
    else $error("shutdown fan state wrong");
endmodule

/* bench/monitor_config_offset_regs_tb.sv */
// Purpose: self-checking bench for the monitor configuration slice
// Assumes: zero-wait APB slave, registers at four times their index
// Notes:   reads are checked from a queue by the bus monitor process
module monitor_config_offset_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import monitor_cfg_pkg::*;
  // ==========================================================
  // Signals
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  logic [7:0]  fan1_min, duty_raw, duty_shown, v, ofs [3];
  logic        fan_drive;
  temp_set_t   temp_raw, temp_adj;
  mode_t       mode;
  logic [32:0] expq [$];
  int          fails, compares;
  logic [11:0] a_ofs [3];
  logic [2:0]  codes [6] = '{CH_2V5, CH_SUPPLY, CH_REMOTE1, CH_LOCAL,
                             CH_REMOTE2, 3'h1};
  chan_sel_t   chans [6] = '{SEL_2V5, SEL_SUPPLY, SEL_REMOTE1, SEL_LOCAL,
                             SEL_REMOTE2, SEL_NONE};
  localparam logic [11:0] A_TEST = {2'b00, ADDR_TEST_EN};
  localparam logic [11:0] A_CFG  = {2'b00, ADDR_CFG_TWO};
  localparam logic [11:0] A_AUX  = {2'b00, ADDR_CTRL_AUX};
  localparam logic [11:0] A_BAD  = 12'h010;

  monitor_config_offset_regs uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fan1_min(fan1_min), .temp_raw(temp_raw), .duty_raw(duty_raw),
    .temp_adj(temp_adj), .mode(mode), .duty_shown(duty_shown),
    .fan_drive(fan_drive));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // ==========================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  task automatic cmp_bus(input logic [32:0] g, input logic [32:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic cmp_val(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    expq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic settle();
    repeat (2) @(posedge pclk);
  endtask

  task automatic final_report();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ==========================================================
  // Read monitor
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0)
      cmp_bus({pslverr, prdata}, expq.pop_front());
  end

  initial begin
    #(50 * 20000);
    fails++;
    final_report();
  end
  // ==========================================================
  // Main sequence
  initial begin
    seed = 32'hCF92D926;
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    fan1_min = 8'h00;
    duty_raw = 8'h00;
    temp_raw = '0;
    a_ofs = '{{2'b00, ADDR_R1_OFS}, {2'b00, ADDR_LOC_OFS},
              {2'b00, ADDR_R2_OFS}};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_TEST, 33'h0);
    rd(A_CFG, 33'h0);
    for (int k = 0; k < 3; k++) rd(a_ofs[k], 33'h0);
    wr(A_TEST, 8'h01);
    rd(A_TEST, 33'h1);
    settle();
    cmp_val(mode.tree_test_mode_on, 1);
    wr(A_TEST, 8'h00);
    settle();
    cmp_val(mode.tree_test_mode_on, 0);
    for (int p = 0; p < 3; p++) begin
      for (int k = 0; k < 3; k++) begin
        ofs[k] = (p == 0) ? 8'h80 : (p == 1) ? 8'h7F : 8'(rnd());
        wr(a_ofs[k], ofs[k]);
        rd(a_ofs[k], {25'h0, ofs[k]});
      end
      temp_raw <= 30'(rnd());
      settle();
      cmp_val(temp_adj.remote1, 10'(temp_raw.remote1
              + {{2{ofs[0][7]}}, ofs[0]}));
      cmp_val(temp_adj.local_t, 10'(temp_raw.local_t
              + {{2{ofs[1][7]}}, ofs[1]}));
      cmp_val(temp_adj.remote2, 10'(temp_raw.remote2
              + {{2{ofs[2][7]}}, ofs[2]}));
    end
    for (int i = 0; i < 9; i++) begin
      v = (i < 8) ? 8'h01 << i : 8'(rnd());
      wr(A_CFG, v);
      rd(A_CFG, {25'h0, v});
      settle();
      cmp_val({mode.power_down_mode, mode.single_channel_convert,
               mode.input_divider_bypass, mode.measurement_averaging,
               mode.two_wire_sense_sel}, v);
    end
    for (int p = 0; p < 2; p++) begin
      wr(A_AUX, 8'(p << 2));
      for (int s = 0; s < 2; s++) begin
        wr(A_CFG, 8'(s << 7));
        duty_raw <= 8'(rnd());
        settle();
        cmp_val(fan_drive, (s == 1) ? p[0] : !p[0]);
        cmp_val(duty_shown, (s == 1) ? 8'h00 : duty_raw);
      end
    end
    wr(A_AUX, 8'h02);
    settle();
    cmp_val(mode.ext_single_channel_convert_clock, 1);
    wr(A_CFG, 8'h40);
    for (int j = 0; j < 6; j++) begin
      fan1_min <= {codes[j], 5'(rnd())};
      settle();
      cmp_val(mode.channel, chans[j]);
    end
    rd(A_BAD, {1'b1, 32'h0});
    wr(A_AUX, 8'h01);
    wr(A_TEST, 8'h01);
    wr(A_CFG, 8'h85);
    for (int k = 0; k < 3; k++) wr(a_ofs[k], ~ofs[k]);
    rd(A_TEST, 33'h0);
    rd(A_CFG, 33'h40);
    for (int k = 0; k < 3; k++) rd(a_ofs[k], {25'h0, ofs[k]});
    settle();
    cmp_val(mode.power_down_mode, 0);
    final_report();
  end
endmodule
